// ===== tap_consts.vh
// constants shared by the boundary scan test port logic
`ifndef TAP_CONSTS_VH
`define TAP_CONSTS_VH

// -----------------------------
// instruction register
// -----------------------------
`define IR_WIDTH 3
`define INS_EXTEST 3'h0
`define INS_IDCODE 3'h1
`define INS_SAMPLE_Z 3'h2
`define INS_SAMPLE 3'h4
`define INS_BYPASS 3'h7
// fixed pattern loaded in capture-IR, low two bits 01 as usual
`define IR_CAPTURE_VAL 3'h1

// -----------------------------
// data registers
// -----------------------------
`define ID_WIDTH 32
`define BSR_LEN 110
`define CELL_OUT_CTRL 109
`define CELL_LOW_A 48
`define CELL_LOW_B 64
`define Q_CELLS 36
`define CQ_CELLS 2

// -----------------------------
// observation buffer
// -----------------------------
`define OBS_DEPTH 16
`define OBS_WIDTH 1

`endif

// ===== tap_logic.v
// boundary scan test access port with observation buffer
`timescale 1ns/1ps
`include "tap_consts.vh"

// -----------------------------
// word buffer with valid/ready on both sides
// -----------------------------
module obs_fifo #(
	parameter WIDTH = `OBS_WIDTH,
	parameter DEPTH = `OBS_DEPTH,
	parameter AW = 4
) (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// filling side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// draining side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0] wr_q;
	reg [AW:0] rd_q;
	wire [AW:0] fill;

	// extra pointer bit tells full from empty
	assign fill = wr_q - rd_q;
	assign in_ready = (fill != DEPTH[AW:0]);
	assign out_valid = (fill != {(AW+1){1'b0}});
	assign out_data = mem[rd_q[AW-1:0]];

	// storage array has no reset, only pointers do
	always @(posedge ref_clk)
	begin
		if (in_valid && in_ready)
			mem[wr_q[AW-1:0]] <= in_data;
	end

	// pointer advance
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (in_valid && in_ready)
				wr_q <= wr_q + 1'b1;
			if (out_valid && out_ready)
				rd_q <= rd_q + 1'b1;
		end
	end
endmodule // obs_fifo

// Functional notes
// - decode 3-bit instruction: 000 extest, 001 id, 010 tristate sample, 100 sample, 111 bypass
// - id instruction captures fixed identity value and shifts the id register
// - id instruction selected at reset and in test-logic-reset
// - bypass places one-bit register between serial input and output in shift-DR
// - extest drives output cells onto pads, captures input pins into input cells
// - extest taking effect in update-IR turns echo drivers on, and data drivers only if cell 109 is high, with preloaded data
// - sample capture-DR loads present input and data output pin values
// - sample then shift-DR shifts the boundary register
// - tristating sample floats read data outputs and shifts the boundary register
// - extest: cell 109 low floats data, echo clocks show update data
// - id, sample, bypass give normal memory output; tristating sample floats both
// - output-control cell updates only in update-DR under extest or sample
// - extest and tristating sample capture actual pad levels of outputs
// - sample: echo cells internal, data cells internal on read else pad
// - cells 48 and 64 always capture low
module tap_logic #(
	parameter [`ID_WIDTH-1:0] ID_VALUE = 32'h0000_0001, // arbitrary identity value
	parameter Q_W = `Q_CELLS,
	parameter IN_W = `BSR_LEN - 1 - `Q_CELLS - `CQ_CELLS
) (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// test port pins
	input wire tck,
	input wire tms,
	input wire tdi,
	output reg tdo_q,
	output reg tdo_oe_q,
	// memory input pins as seen by the boundary cells
	input wire [IN_W-1:0] mem_in,
	// memory core outputs
	input wire [Q_W-1:0] sram_q,
	input wire sram_q_oe,
	input wire echo_clock_int,
	input wire echo_clock_int_inverted,
	// pad levels read back
	input wire [Q_W-1:0] q_pad_in,
	input wire echo_clock_pad,
	input wire echo_clock_pad_inverted,
	// pad drivers
	output reg [Q_W-1:0] q_out_q,
	output reg q_oe_q,
	output reg echo_clock_out_q,
	output reg echo_clock_out_inverted_q,
	output reg echo_oe_q,
	// instruction seen outside
	output reg instruction_bit_high_q,
	output reg instruction_bit_low_q,
	// observation stream of bits shifted into data registers
	output reg obs_valid_q,
	output reg obs_data_q,
	input wire obs_ready,
	output reg obs_room_q
);
	localparam BL = `BSR_LEN;
	localparam CQ_LO = IN_W + Q_W;
	// controller states
	localparam ST_RESET = 4'h0;
	localparam ST_IDLE = 4'h1;
	localparam ST_SEL_DR = 4'h2;
	localparam ST_CAP_DR = 4'h3;
	localparam ST_SH_DR = 4'h4;
	localparam ST_EX1_DR = 4'h5;
	localparam ST_PA_DR = 4'h6;
	localparam ST_EX2_DR = 4'h7;
	localparam ST_UP_DR = 4'h8;
	localparam ST_SEL_IR = 4'h9;
	localparam ST_CAP_IR = 4'ha;
	localparam ST_SH_IR = 4'hb;
	localparam ST_EX1_IR = 4'hc;
	localparam ST_PA_IR = 4'hd;
	localparam ST_EX2_IR = 4'he;
	localparam ST_UP_IR = 4'hf;

	reg tck_s1_q, tck_s2_q, tck_s3_q;
	reg tms_s1_q, tms_s2_q;
	reg tdi_s1_q, tdi_s2_q;
	reg [3:0] st_q;
	reg [3:0] st_d;
	reg [`IR_WIDTH-1:0] ir_sh_q;
	reg [`IR_WIDTH-1:0] ir_q;
	reg [`ID_WIDTH-1:0] id_q;
	reg byp_q;
	reg [BL-1:0] bsr_q;
	reg [BL-1:0] upd_q;
	reg [BL-1:0] cap_d;
	reg tdo_d;
	wire rise;
	wire fall;
	wire f_valid;
	wire f_ready;
	wire f_data;
	wire f_in_ready;

	// boundary register path selected for this instruction
	function uses_bsr;
		input [`IR_WIDTH-1:0] ins;
		begin
			uses_bsr = (ins == `INS_EXTEST) || (ins == `INS_SAMPLE) ||
				(ins == `INS_SAMPLE_Z);
		end
	endfunction

	// -----------------------------
	// pin synchronisers and edge finding
	// -----------------------------
	// the test clock is foreign to ref_clk, so every pin takes two flops first
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tck_s1_q <= 1'b0;
			tck_s2_q <= 1'b0;
			tck_s3_q <= 1'b0;
			tms_s1_q <= 1'b1;
			tms_s2_q <= 1'b1;
			tdi_s1_q <= 1'b1;
			tdi_s2_q <= 1'b1;
		end
		else
		begin
			tck_s1_q <= tck;
			tck_s2_q <= tck_s1_q;
			tck_s3_q <= tck_s2_q;
			tms_s1_q <= tms;
			tms_s2_q <= tms_s1_q;
			tdi_s1_q <= tdi;
			tdi_s2_q <= tdi_s1_q;
		end
	end
	assign rise = tck_s2_q && !tck_s3_q;
	assign fall = !tck_s2_q && tck_s3_q;

	// -----------------------------
	// controller
	// -----------------------------
	// next state from mode input
	always @*
	begin
		case (st_q)
			ST_RESET: st_d = tms_s2_q ? ST_RESET : ST_IDLE;
			ST_IDLE: st_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: st_d = tms_s2_q ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: st_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: st_d = tms_s2_q ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: st_d = tms_s2_q ? ST_UP_DR : ST_PA_DR;
			ST_PA_DR: st_d = tms_s2_q ? ST_EX2_DR : ST_PA_DR;
			ST_EX2_DR: st_d = tms_s2_q ? ST_UP_DR : ST_SH_DR;
			ST_UP_DR: st_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: st_d = tms_s2_q ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: st_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: st_d = tms_s2_q ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: st_d = tms_s2_q ? ST_UP_IR : ST_PA_IR;
			ST_PA_IR: st_d = tms_s2_q ? ST_EX2_IR : ST_PA_IR;
			ST_EX2_IR: st_d = tms_s2_q ? ST_UP_IR : ST_SH_IR;
			ST_UP_IR: st_d = tms_s2_q ? ST_SEL_DR : ST_IDLE;
			default: st_d = ST_RESET;
		endcase
	end

	// -----------------------------
	// capture sources of the boundary cells
	// -----------------------------
	always @*
	begin
		cap_d = bsr_q;
		// input pins are sampled as they stand
		cap_d[IN_W-1:0] = mem_in;
		if (ir_q == `INS_SAMPLE)
		begin
			// on a read the core drives the pads; when idle only the pad tells
			cap_d[IN_W +: Q_W] = sram_q_oe ? sram_q : q_pad_in;
			cap_d[CQ_LO] = echo_clock_int;
			cap_d[CQ_LO+1] = echo_clock_int_inverted;
		end
		else
		begin
			// extest and tristating sample read the real pads; others undefined
			cap_d[IN_W +: Q_W] = q_pad_in;
			cap_d[CQ_LO] = echo_clock_pad;
			cap_d[CQ_LO+1] = echo_clock_pad_inverted;
		end
		cap_d[`CELL_OUT_CTRL] = upd_q[`CELL_OUT_CTRL];
		cap_d[`CELL_LOW_A] = 1'b0;
		cap_d[`CELL_LOW_B] = 1'b0;
	end

	// serial output value for the current shift path
	always @*
	begin
		tdo_d = 1'b0;
		if (st_q == ST_SH_IR)
			tdo_d = ir_sh_q[0];
		else if (st_q == ST_SH_DR)
		begin
			if (ir_q == `INS_IDCODE)
				tdo_d = id_q[0];
			else if (uses_bsr(ir_q))
				tdo_d = bsr_q[0];
			else
				tdo_d = byp_q;
		end
	end

	// -----------------------------
	// test clock rising edge work
	// -----------------------------
	// reserved codes fall to the bypass path, the safe short chain
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q <= ST_RESET;
			ir_q <= `INS_IDCODE;
			ir_sh_q <= `IR_CAPTURE_VAL;
			id_q <= {`ID_WIDTH{1'b0}};
			byp_q <= 1'b0;
			bsr_q <= {BL{1'b0}};
			upd_q <= {BL{1'b0}};
		end
		else if (rise)
		begin
			st_q <= st_d;
			case (st_q)
				ST_RESET: ir_q <= `INS_IDCODE;
				ST_CAP_IR: ir_sh_q <= `IR_CAPTURE_VAL;
				ST_SH_IR: ir_sh_q <= {tdi_s2_q, ir_sh_q[`IR_WIDTH-1:1]};
				ST_UP_IR: ir_q <= ir_sh_q;
				ST_CAP_DR:
				begin
					if (ir_q == `INS_IDCODE)
						id_q <= ID_VALUE;
					else if (uses_bsr(ir_q))
						bsr_q <= cap_d;
					else
						byp_q <= 1'b0;
				end
				ST_SH_DR:
				begin
					if (ir_q == `INS_IDCODE)
						id_q <= {tdi_s2_q, id_q[`ID_WIDTH-1:1]};
					else if (uses_bsr(ir_q))
						bsr_q <= {tdi_s2_q, bsr_q[BL-1:1]};
					else
						byp_q <= tdi_s2_q;
				end
				ST_UP_DR:
				begin
					// preload lands here under sample, so extest finds it ready
					if ((ir_q == `INS_EXTEST) || (ir_q == `INS_SAMPLE))
						upd_q <= bsr_q;
				end
				default: ;
			endcase
		end
	end

	// -----------------------------
	// serial output on test clock falling edge
	// -----------------------------
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			tdo_q <= 1'b0;
			tdo_oe_q <= 1'b0;
		end
		else if (fall)
		begin
			tdo_q <= tdo_d;
			tdo_oe_q <= (st_q == ST_SH_IR) || (st_q == ST_SH_DR);
		end
	end

	// -----------------------------
	// pad drivers
	// -----------------------------
	// registered, so pads lag the instruction by one ref_clk cycle
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			q_out_q <= {Q_W{1'b0}};
			q_oe_q <= 1'b0;
			echo_clock_out_q <= 1'b0;
			echo_clock_out_inverted_q <= 1'b0;
			echo_oe_q <= 1'b0;
			instruction_bit_high_q <= 1'b0;
			instruction_bit_low_q <= 1'b1;
		end
		else
		begin
			instruction_bit_high_q <= ir_q[`IR_WIDTH-1];
			instruction_bit_low_q <= ir_q[0];
			case (ir_q)
				`INS_EXTEST:
				begin
					q_out_q <= upd_q[IN_W +: Q_W];
					q_oe_q <= upd_q[`CELL_OUT_CTRL];
					echo_clock_out_q <= upd_q[CQ_LO];
					echo_clock_out_inverted_q <= upd_q[CQ_LO+1];
					echo_oe_q <= 1'b1;
				end
				`INS_SAMPLE_Z:
				begin
					q_out_q <= sram_q;
					q_oe_q <= 1'b0;
					echo_clock_out_q <= echo_clock_int;
					echo_clock_out_inverted_q <= echo_clock_int_inverted;
					echo_oe_q <= 1'b0;
				end
				default:
				begin
					q_out_q <= sram_q;
					q_oe_q <= sram_q_oe;
					echo_clock_out_q <= echo_clock_int;
					echo_clock_out_inverted_q <= echo_clock_int_inverted;
					echo_oe_q <= 1'b1;
				end
			endcase
		end
	end

	// -----------------------------
	// observation stream
	// -----------------------------
	// a full buffer drops bits; obs_room_q low warns the observer of that
	obs_fifo #(
		.WIDTH(`OBS_WIDTH),
		.DEPTH(`OBS_DEPTH),
		.AW(4)
	) u_obs (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.in_valid(rise && (st_q == ST_SH_DR)),
		.in_ready(f_in_ready),
		.in_data(tdi_s2_q),
		.out_valid(f_valid),
		.out_ready(f_ready),
		.out_data(f_data)
	);
	assign f_ready = !obs_valid_q || obs_ready;

	// output stage keeps the stream ports on flops
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			obs_valid_q <= 1'b0;
			obs_data_q <= 1'b0;
			obs_room_q <= 1'b0;
		end
		else
		begin
			obs_room_q <= f_in_ready;
			if (f_ready)
			begin
				obs_valid_q <= f_valid;
				obs_data_q <= f_data;
			end
		end
	end
endmodule // tap_logic

// ===== tap_logic_props.sv
// concurrent checks on the pins of the boundary scan test port
`timescale 1ns/1ps
module tap_logic_props #(
	parameter Q_W = 36
) (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// test port
	input wire tck,
	input wire tdo_q,
	input wire tdo_oe_q,
	// core outputs
	input wire [Q_W-1:0] sram_q,
	input wire sram_q_oe,
	input wire echo_clock_int,
	// pads and instruction
	input wire [Q_W-1:0] q_out_q,
	input wire q_oe_q,
	input wire echo_clock_out_q,
	input wire echo_oe_q,
	input wire instruction_bit_high_q,
	input wire instruction_bit_low_q,
	// observation stream
	input wire obs_valid_q,
	input wire obs_data_q,
	input wire obs_ready,
	input wire obs_room_q
);
	reg [1:0] live_q;
	wire sram_mode;
	// id, sample and bypass each set at least one of these bits; extest and sample-z set none
	assign sram_mode = instruction_bit_high_q | instruction_bit_low_q;
	// history is trusted two edges after reset, once $past no longer sees reset values
	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
			live_q <= 2'b00;
		else
			live_q <= {live_q[0], 1'b1};
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	// --------------------------------
	// assertions
	// --------------------------------
	a_reset_state: assert property ($rose(nrst) |-> !tdo_oe_q && instruction_bit_low_q
		&& !instruction_bit_high_q && !obs_valid_q) else $error("state after reset wrong");
	// pads and instruction copies load on the same edge, so one sample serves both
	a_sram_data: assert property (live_q[1] && sram_mode |->
		q_out_q == $past(sram_q) && q_oe_q == $past(sram_q_oe)) else $error("data pads wrong");
	a_sram_echo: assert property (live_q[1] && sram_mode |->
		echo_oe_q && echo_clock_out_q == $past(echo_clock_int)) else $error("echo pads wrong");
	a_float_pair: assert property (live_q[1] && !sram_mode |->
		!q_oe_q || echo_oe_q) else $error("data driven with echo floating");
	a_tdo_fall: assert property (live_q[1] && $changed(tdo_q) |-> !$past(tck, 2))
		else $error("serial out moved outside a falling test clock");
	a_oe_rise: assert property (live_q[1] && $rose(tdo_oe_q) |-> !$past(tck, 2))
		else $error("serial enable rose outside a falling test clock");
	a_update_rise: assert property (live_q[1] && !sram_mode && !$past(sram_mode)
		&& echo_oe_q && $past(echo_oe_q) && ($changed(q_out_q) || $changed(q_oe_q))
		|-> $past(tck, 2)) else $error("update cells moved off a rising test clock");
	a_obs_hold: assert property (live_q[1] && obs_valid_q && !obs_ready |=> // stream handshake
		obs_valid_q && $stable(obs_data_q)) else $error("stream word dropped while stalled");
	a_full_shows: assert property (live_q[1] && !obs_room_q |-> ##[0:3] obs_valid_q) // buffer
		else $error("full buffer shows no word");
	// main scenarios reached
	c_extest_drive: cover property (q_oe_q && !sram_mode);
	c_float: cover property (!q_oe_q && !echo_oe_q);
	c_full: cover property (!obs_room_q);
endmodule // tap_logic_props

// ===== jtag_host.sv
// board-side test controller model driving the test port pins
`timescale 1ns/1ps
module jtag_host (
	// system clock paces the test clock
	input wire ref_clk,
	// test port
	input wire tdo,
	output reg tck,
	output reg tms,
	output reg tdi
);
	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end
	// one 160 ns test clock: inputs move with the fall, tdo taken just before the rise
	task step(input m, input d, output o);
	begin
		@(negedge ref_clk);
		tck = 1'b0;
		tms = m;
		tdi = d;
		repeat (4) @(negedge ref_clk);
		o = tdo;
		tck = 1'b1;
		repeat (3) @(negedge ref_clk);
	end
	endtask
	// five highs reach test-logic-reset from any state, then park in idle
	task go_idle;
		reg o;
		integer i;
	begin
		for (i = 0; i < 5; i = i + 1)
			step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
	end
	endtask
	// idle to idle scan, lsb first; unused tdi toggles so a stale bit never passes
	task scan(input ir, input integer n, input [127:0] din, output [127:0] dout);
		reg o;
		integer i;
	begin
		dout = 128'h0;
		step(1'b1, ~tdi, o);
		if (ir)
			step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
		step(1'b0, ~tdi, o);
		for (i = 0; i < n; i = i + 1)
		begin
			step(i == n - 1, din[i], o);
			dout[i] = o;
		end
		step(1'b1, ~tdi, o);
		step(1'b0, ~tdi, o);
		// pads and instruction copies register one ref_clk after the update work
		@(negedge ref_clk);
	end
	endtask
endmodule // jtag_host

// ===== tap_logic_tb.sv
// self-checking bench for the boundary scan test port
`timescale 1ns/1ps
`include "tap_consts.vh"
module tap_logic_tb;
	localparam [31:0] ID = 32'h0000_0001; // arbitrary identity value
	localparam [109:0] PRE = {3'h5, 36'h9_1234_5678, 71'h0};
	localparam [109:0] PRE2 = {3'h3, 36'h9_1234_5678, 71'h0};
	reg ref_clk, nrst, sram_q_oe, obs_ready;
	reg echo_clock_int, echo_clock_int_inverted, echo_clock_pad, echo_clock_pad_inverted;
	reg [70:0] mem_in;
	reg [35:0] sram_q, q_pad_in;
	reg [127:0] got;
	reg [109:0] e;
	reg [15:0] bits;
	wire tck, tms, tdi, tdo_q, tdo_oe_q, q_oe_q, echo_clock_out_q, echo_clock_out_inverted_q;
	wire echo_oe_q, instruction_bit_high_q, instruction_bit_low_q, obs_valid_q, obs_data_q;
	wire obs_room_q;
	wire [35:0] q_out_q;
	integer failures, n_checks, i, cnt;
	// --------------------------------
	// clock, design and host
	// --------------------------------
	initial ref_clk = 1'b0;
	always #10 ref_clk = ~ref_clk;
	tap_logic #(.ID_VALUE(ID)) DUT (.ref_clk(ref_clk), .nrst(nrst), .tck(tck), .tms(tms),
		.tdi(tdi), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .mem_in(mem_in), .sram_q(sram_q),
		.sram_q_oe(sram_q_oe), .echo_clock_int(echo_clock_int),
		.echo_clock_int_inverted(echo_clock_int_inverted), .q_pad_in(q_pad_in),
		.echo_clock_pad(echo_clock_pad), .echo_clock_pad_inverted(echo_clock_pad_inverted),
		.q_out_q(q_out_q), .q_oe_q(q_oe_q), .echo_clock_out_q(echo_clock_out_q),
		.echo_clock_out_inverted_q(echo_clock_out_inverted_q), .echo_oe_q(echo_oe_q),
		.instruction_bit_high_q(instruction_bit_high_q),
		.instruction_bit_low_q(instruction_bit_low_q), .obs_valid_q(obs_valid_q),
		.obs_data_q(obs_data_q), .obs_ready(obs_ready), .obs_room_q(obs_room_q));
	jtag_host host (.ref_clk(ref_clk), .tdo(tdo_q), .tck(tck), .tms(tms), .tdi(tdi));
	// expected capture: sample takes the core echo clocks, and core data on a read; otherwise the pads
	function [109:0] cap_exp(input smp);
		cap_exp = {1'b0, smp ? echo_clock_int_inverted : echo_clock_pad_inverted,
			smp ? echo_clock_int : echo_clock_pad, (smp && sram_q_oe) ? sram_q : q_pad_in,
			mem_in & ~(71'h1 << 48) & ~(71'h1 << 64)};
	endfunction
	task check(input [127:0] g, input [127:0] x);
	begin
		n_checks = n_checks + 1;
		if (g !== x)
		begin
			failures = failures + 1;
			$display("Error at %0t: got %h expected %h", $time, g, x);
		end
	end
	endtask
	task load_ir(input [2:0] c);
	begin
		host.scan(1'b1, 3, {125'h0, c}, got); // only listed codes are passed
		check(got[2:0], `IR_CAPTURE_VAL);
		check({instruction_bit_high_q, instruction_bit_low_q}, {c[2], c[0]});
	end
	endtask
	// --------------------------------
	// scenarios
	// --------------------------------
	task t_idcode;
	begin
		host.go_idle;
		check({instruction_bit_high_q, instruction_bit_low_q}, 2'h1);
		host.scan(1'b0, 32, 128'h0, got);
		check(got[31:0], ID);
		$display("idcode test done");
	end
	endtask
	// stall the drain so the buffer refuses, then empty it in order
	task t_fifo;
	begin
		load_ir(`INS_IDCODE);
		@(negedge ref_clk);
		obs_ready = 1'b0;
		host.scan(1'b0, 20, 128'ha_53c9, got);
		check(obs_room_q, 1'b0);
		@(negedge ref_clk);
		obs_ready = 1'b1;
		cnt = 0;
		for (i = 0; i < 60; i = i + 1)
		begin
			if (obs_valid_q === 1'b1 && cnt < 16)
				bits[cnt] = obs_data_q;
			if (obs_valid_q === 1'b1)
				cnt = cnt + 1;
			@(negedge ref_clk);
		end
		check(bits, 16'h53c9);
		check(obs_valid_q, 1'b0);
		$display("buffer test done");
	end
	endtask
	// read and idle core, preloading the first extest vector both times
	task t_sample;
	begin
		load_ir(`INS_SAMPLE);
		for (i = 0; i < 2; i = i + 1)
		begin
			@(negedge ref_clk);
			sram_q_oe = (i == 0); // then held through the capture
			host.scan(1'b0, 110, PRE, got);
			e = cap_exp(1'b1);
			check(got[108:0], e[108:0]);
			check({q_out_q, q_oe_q, echo_oe_q}, {sram_q, sram_q_oe, 1'b1});
		end
		$display("sample test done");
	end
	endtask
	// update-DR here must leave the preloaded cells alone
	task t_samplez;
	begin
		load_ir(`INS_SAMPLE_Z);
		check({q_oe_q, echo_oe_q}, 2'h0);
		host.scan(1'b0, 110, 128'h0, got);
		e = cap_exp(1'b0);
		check(got[108:0], e[108:0]);
		$display("sample-z test done");
	end
	endtask
	task t_extest;
	begin
		load_ir(`INS_EXTEST);
		check({q_out_q, q_oe_q, echo_clock_out_q, echo_oe_q}, {36'h9_1234_5678, 3'h7});
		check(echo_clock_out_inverted_q, 1'b0);
		host.scan(1'b0, 110, PRE2, got);
		e = cap_exp(1'b0);
		e[109] = 1'b1;
		check(got[109:0], e);
		check({q_oe_q, echo_oe_q, echo_clock_out_q}, 3'h3);
		check(echo_clock_out_inverted_q, 1'b1);
		$display("extest test done");
	end
	endtask
	task t_bypass;
	begin
		load_ir(`INS_BYPASS);
		host.scan(1'b0, 8, 128'hb2, got);
		check(got[7:0], 8'h64);
		$display("bypass test done");
	end
	endtask
	task tally_and_finish;
	begin
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	// watchdog well past the expected 100 us of scanning
	initial
	begin
		#400000;
		failures = failures + 1;
		$display("Error at %0t: watchdog got %h expected %h", $time, 1'b0, 1'b1);
		tally_and_finish;
	end
	initial
	begin
		failures = 0;
		n_checks = 0;
		nrst = 1'b0;
		obs_ready = 1'b1;
		sram_q_oe = 1'b1;
		sram_q = 36'ha_5a5a_5a5a;
		q_pad_in = 36'h3_c3c3_c3c3;
		mem_in = {1'b1, {35{2'b01}}};
		echo_clock_int = 1'b1;
		echo_clock_int_inverted = 1'b0;
		echo_clock_pad = 1'b0;
		echo_clock_pad_inverted = 1'b1;
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
		nrst = 1'b1;
		t_idcode;
		t_fifo;
		t_sample;
		t_samplez;
		t_extest;
		t_bypass;
		t_idcode; // test-logic-reset after bypass
		tally_and_finish;
	end
endmodule // tap_logic_tb
bind tap_logic tap_logic_props #(.Q_W(Q_W)) props (.ref_clk(ref_clk), .nrst(nrst),
	.tck(tck), .tdo_q(tdo_q), .tdo_oe_q(tdo_oe_q), .sram_q(sram_q), .sram_q_oe(sram_q_oe),
	.echo_clock_int(echo_clock_int), .q_out_q(q_out_q), .q_oe_q(q_oe_q),
	.echo_clock_out_q(echo_clock_out_q), .echo_oe_q(echo_oe_q),
	.instruction_bit_high_q(instruction_bit_high_q),
	.instruction_bit_low_q(instruction_bit_low_q), .obs_valid_q(obs_valid_q),
	.obs_data_q(obs_data_q), .obs_ready(obs_ready), .obs_room_q(obs_room_q));
